// ---- twst_bus_master.sv ----
`timescale 1ns/10ps
`default_nettype none

module twst_bus_master
(
	input  wire logic sclLine,
	input  wire logic sdaLine,
	output var logic  sclLow,
	output var logic  sdaLow
);
	// Both lines start released, so the pull-ups give the idle level.
	initial
	begin
		sclLow = 1'b0;
		sdaLow = 1'b0;
	end

	// One 200 ns bus clock; waiting on the line itself honours a stretched clock.
	task automatic bitCycle(input logic drv, output logic seen);
		#13 sdaLow = !drv;
		#87 sclLow = 1'b0;
		wait (sclLine === 1'b1);
		#50 seen = sdaLine;
		#50 sclLow = 1'b1;
	endtask : bitCycle

	// Start, also repeated start: SDA falls while SCL is high.
	task automatic startCond();
		#13 sdaLow = 1'b0;
		#87 sclLow = 1'b0;
		wait (sclLine === 1'b1);
		#50 sdaLow = 1'b1;
		#50 sclLow = 1'b1;
	endtask : startCond

	// Stop: SDA rises while SCL is high, then both stay released.
	task automatic stopCond();
		#13 sdaLow = 1'b1;
		#87 sclLow = 1'b0;
		wait (sclLine === 1'b1);
		#50 sdaLow = 1'b0;
		#100;
	endtask : stopCond

	// Address byte out, acknowledge read back in the ninth clock.
	task automatic sendByte(input logic [7:0] b, output logic acked);
		logic s;
		for (int i = 7; i >= 0; i--)
			bitCycle(b[i], s);
		bitCycle(1'b1, s);
		acked = !s;
	endtask : sendByte

	// Data byte in; the master acknowledges or refuses as the test asks.
	task automatic getByte(input logic ackIt, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--)
			bitCycle(1'b1, b[i]);
		bitCycle(!ackIt, s);
	endtask : getByte
endmodule : twst_bus_master

`default_nettype wire

// ---- twst_line_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

module twst_line_sync
(
	input  wire logic          clock,
	input  wire logic          reset,
	input  wire logic          sclPin,
	input  wire logic          sdaPin,
	output twst_pkg::twst_line_s line
);

	logic sclMeta_q;
	logic sdaMeta_q;
	logic scl_q;
	logic sda_q;
	logic sclPrev_q;
	logic sdaPrev_q;

	// Three flip-flops per pin; the idle bus reads high, so reset to one.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			sclMeta_q <= 1'b1;
			sdaMeta_q <= 1'b1;
			scl_q     <= 1'b1;
			sda_q     <= 1'b1;
			sclPrev_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end
		else
		begin
			sclMeta_q <= sclPin;
			sdaMeta_q <= sdaPin;
			scl_q     <= sclMeta_q;
			sda_q     <= sdaMeta_q;
			sclPrev_q <= scl_q;
			sdaPrev_q <= sda_q;
		end
	end

	// Edges and bus conditions look only at the settled stages.
	assign line.scl       = scl_q;
	assign line.sda       = sda_q;
	assign line.sclRise   = scl_q & ~sclPrev_q;
	assign line.sclFall   = ~scl_q & sclPrev_q;
	assign line.startSeen = scl_q & sclPrev_q & sdaPrev_q & ~sda_q;
	assign line.stopSeen  = scl_q & sclPrev_q & ~sdaPrev_q & sda_q;

endmodule : twst_line_sync

`default_nettype wire

// ---- twst_pkg.sv ----
`default_nettype none

package twst_pkg;

	// Register byte offsets on the bus, one aligned word each.
	localparam logic [7:0] ADDR_DATA     = 8'h00;
	localparam logic [7:0] ADDR_CTRL     = 8'h04;
	localparam logic [7:0] ADDR_STATUS   = 8'h08;
	localparam logic [7:0] ADDR_OWN      = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

	// Control register field positions.
	localparam int CTRL_FLAG_BIT   = 7;
	localparam int CTRL_ACK_BIT    = 6;
	localparam int CTRL_START_BIT  = 5;
	localparam int CTRL_STOP_BIT   = 4;
	localparam int CTRL_ENABLE_BIT = 2;

	// Own address register: address in bits 7..1, general call enable in bit 0.
	localparam int OWN_GCE_BIT = 0;

	// Interrupt status and mask bit positions.
	localparam int IRQ_DONE_BIT  = 0;
	localparam int IRQ_STOP_BIT  = 1;
	localparam int IRQ_GCALL_BIT = 2;
	localparam int IRQ_WIDTH     = 3;

	// Reset values.
	localparam logic [7:0]           RESET_DATA = 8'h00;
	localparam logic [7:0]           RESET_OWN  = 8'h00;
	localparam logic [IRQ_WIDTH-1:0] RESET_IRQ  = 3'h0;

	// Status codes reported to software.
	localparam logic [7:0] ST_OWN_READ      = 8'hA8;
	localparam logic [7:0] ST_ARB_LOST_READ = 8'hB0;
	localparam logic [7:0] ST_DATA_ACK      = 8'hB8;
	localparam logic [7:0] ST_DATA_NACK     = 8'hC0;
	localparam logic [7:0] ST_LAST_ACK      = 8'hC8;
	localparam logic [7:0] ST_START_SENT    = 8'h08;
	localparam logic [7:0] ST_NO_INFO       = 8'hF8;

	// Timing: start and stop hold time on the bus.
	localparam int CLOCK_PERIOD_NS   = 25;
	localparam int START_HOLD_NS     = 4000;
	localparam int START_HOLD_CYCLES = (START_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

	// Software-owned control fields.
	typedef struct packed {
		logic ackEnable;
		logic startRequest;
		logic enable;
	} twst_ctrl_s;

	localparam twst_ctrl_s RESET_CTRL = '{ackEnable: 1'b0, startRequest: 1'b0, enable: 1'b0};

	// Synchronised bus line view and its events.
	typedef struct packed {
		logic scl;
		logic sda;
		logic sclRise;
		logic sclFall;
		logic startSeen;
		logic stopSeen;
	} twst_line_s;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_TX_HOLD,
		ST_TX_BITS,
		ST_TX_ACK,
		ST_END_HOLD,
		ST_START_GEN,
		ST_START_HOLD,
		ST_STOP_GEN
	} twst_state_e;

endpackage : twst_pkg

`default_nettype wire

// ---- twst_slave_transmitter.sv ----
`timescale 1ns/10ps
`default_nettype none

module twst_slave_transmitter
(
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        sclIn,
	output logic             sclOut,
	output logic             sclOe,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOe,
	output logic             irq
);

	twst_pkg::twst_line_s  line;
	twst_pkg::twst_ctrl_s  ctrl_q;
	twst_pkg::twst_state_e state_q;

	logic                          phaseValid_q;
	logic                          phaseWrite_q;
	logic [7:0]                    phaseAddr_q;
	logic                          readWait_q;
	logic [31:0]                   hrdata_q;
	logic [7:0]                    data_q;
	logic [7:0]                    own_q;
	logic                          flag_q;
	logic [7:0]                    status_q;
	logic [twst_pkg::IRQ_WIDTH-1:0] irqStat_q;
	logic [twst_pkg::IRQ_WIDTH-1:0] irqMask_q;
	logic                          setFlag_q;
	logic [7:0]                    setCode_q;
	logic                          clrStart_q;
	logic                          evStop_q;
	logic                          evGcall_q;
	logic [7:0]                    shift_q;
	logic [3:0]                    bitCnt_q;
	logic [11:0]                   holdCnt_q;
	logic                          sdaDrive_q;
	logic                          lastByte_q;
	logic                          ackSeen_q;
	logic                          addressable_q;
	logic                          busBusy_q;
	logic                          arbLost_q;
	logic                          wrEn;
	logic                          ctrlWrite;
	logic                          flagClr;
	logic                          addressed;
	logic [twst_pkg::IRQ_WIDTH-1:0] irqEvents;

	localparam logic [11:0] HOLD_LAST = 12'(twst_pkg::START_HOLD_CYCLES - 1);

	// Register read decode; unmapped offsets read as zero.
	function automatic logic [31:0] readReg(input logic [7:0] addr);
		logic [31:0] value;
		value = 32'h0000_0000;
		if (addr == twst_pkg::ADDR_DATA)
			value[7:0] = data_q;
		else if (addr == twst_pkg::ADDR_CTRL)
			value[7:0] = {flag_q, ctrl_q.ackEnable, ctrl_q.startRequest, 2'h0, ctrl_q.enable, 2'h0};
		else if (addr == twst_pkg::ADDR_STATUS)
			value[7:0] = status_q;
		else if (addr == twst_pkg::ADDR_OWN)
			value[7:0] = own_q;
		else if (addr == twst_pkg::ADDR_IRQ_STAT)
			value[twst_pkg::IRQ_WIDTH-1:0] = irqStat_q;
		else if (addr == twst_pkg::ADDR_IRQ_MASK)
			value[twst_pkg::IRQ_WIDTH-1:0] = irqMask_q;
		return value;
	endfunction : readReg

	twst_line_sync twst_line_sync_inst
	(
		.clock  (clock),
		.reset  (reset),
		.sclPin (sclIn),
		.sdaPin (sdaIn),
		.line   (line)
	);

	// Bus slave: writes finish with no wait, reads take one wait state so hrdata comes from a flip-flop.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			phaseValid_q <= 1'b0;
			phaseWrite_q <= 1'b0;
			phaseAddr_q  <= 8'h00;
			readWait_q   <= 1'b0;
			hrdata_q     <= 32'h0000_0000;
		end
		else if (readWait_q)
		begin
			readWait_q <= 1'b0;
			hrdata_q   <= readReg(phaseAddr_q);
		end
		else if (hready)
		begin
			phaseValid_q <= hsel & htrans[1];
			phaseWrite_q <= hwrite;
			phaseAddr_q  <= haddr[7:0];
			readWait_q   <= hsel & htrans[1] & ~hwrite;
		end
	end

	assign hreadyout = ~readWait_q;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;
	assign wrEn      = phaseValid_q & phaseWrite_q;
	assign ctrlWrite = wrEn & (phaseAddr_q == twst_pkg::ADDR_CTRL);
	// Writing one to the flag bit is what hands the bus back to the hardware.
	assign flagClr   = ctrlWrite & hwdata[twst_pkg::CTRL_FLAG_BIT] & flag_q & ~setFlag_q;

	// Software registers; hardware setting the flag wins over a clear in the same cycle.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			data_q   <= twst_pkg::RESET_DATA;
			own_q    <= twst_pkg::RESET_OWN;
			ctrl_q   <= twst_pkg::RESET_CTRL;
			flag_q   <= 1'b0;
			status_q <= twst_pkg::ST_NO_INFO;
		end
		else
		begin
			if (wrEn && phaseAddr_q == twst_pkg::ADDR_DATA && flag_q)
				data_q <= hwdata[7:0];
			if (wrEn && phaseAddr_q == twst_pkg::ADDR_OWN)
				own_q <= hwdata[7:0];
			if (ctrlWrite)
			begin
				ctrl_q.ackEnable    <= hwdata[twst_pkg::CTRL_ACK_BIT];
				ctrl_q.startRequest <= hwdata[twst_pkg::CTRL_START_BIT];
				ctrl_q.enable       <= hwdata[twst_pkg::CTRL_ENABLE_BIT];
			end
			else if (clrStart_q)
				ctrl_q.startRequest <= 1'b0;
			if (setFlag_q)
			begin
				flag_q   <= 1'b1;
				status_q <= setCode_q;
			end
			else if (flagClr)
			begin
				flag_q   <= 1'b0;
				status_q <= twst_pkg::ST_NO_INFO;
			end
		end
	end

	// Sticky interrupt status, write one to clear; a new event beats the clear.
	assign irqEvents = {evGcall_q, evStop_q, setFlag_q};

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			irqStat_q <= twst_pkg::RESET_IRQ;
			irqMask_q <= twst_pkg::RESET_IRQ;
		end
		else
		begin
			if (wrEn && phaseAddr_q == twst_pkg::ADDR_IRQ_MASK)
				irqMask_q <= hwdata[twst_pkg::IRQ_WIDTH-1:0];
			if (wrEn && phaseAddr_q == twst_pkg::ADDR_IRQ_STAT)
				irqStat_q <= (irqStat_q & ~hwdata[twst_pkg::IRQ_WIDTH-1:0]) | irqEvents;
			else
				irqStat_q <= irqStat_q | irqEvents;
		end
	end

	assign irq = |(irqStat_q & irqMask_q);

	assign addressed = (state_q == twst_pkg::ST_ADDR_ACK) || (state_q == twst_pkg::ST_TX_HOLD)
		|| (state_q == twst_pkg::ST_TX_BITS) || (state_q == twst_pkg::ST_TX_ACK)
		|| (state_q == twst_pkg::ST_END_HOLD);

	// Bus-side sequencer; an own-address match, each sent byte and a generated start report to software through a one-cycle flag pulse.
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			state_q       <= twst_pkg::ST_IDLE;
			setFlag_q     <= 1'b0;
			setCode_q     <= twst_pkg::ST_NO_INFO;
			clrStart_q    <= 1'b0;
			evStop_q      <= 1'b0;
			evGcall_q     <= 1'b0;
			shift_q       <= 8'h00;
			bitCnt_q      <= 4'h0;
			holdCnt_q     <= 12'h000;
			sdaDrive_q    <= 1'b0;
			lastByte_q    <= 1'b0;
			ackSeen_q     <= 1'b0;
			addressable_q <= 1'b0;
			busBusy_q     <= 1'b0;
			arbLost_q     <= 1'b0;
		end
		else
		begin
			setFlag_q  <= 1'b0;
			clrStart_q <= 1'b0;
			evStop_q   <= 1'b0;
			evGcall_q  <= 1'b0;
			// Any control write outside the final hold sets recognition from ack-enable.
			if (ctrlWrite && state_q != twst_pkg::ST_END_HOLD)
				addressable_q <= hwdata[twst_pkg::CTRL_ACK_BIT];
			if (line.stopSeen)
				busBusy_q <= 1'b0;
			if (line.startSeen)
				busBusy_q <= 1'b1;
			if (!ctrl_q.enable)
			begin
				state_q    <= twst_pkg::ST_IDLE;
				sdaDrive_q <= 1'b0;
			end
			else if (line.stopSeen && state_q != twst_pkg::ST_STOP_GEN && state_q != twst_pkg::ST_START_HOLD)
			begin
				evStop_q   <= addressed;
				state_q    <= twst_pkg::ST_IDLE;
				sdaDrive_q <= 1'b0;
			end
			else if (line.startSeen && state_q != twst_pkg::ST_START_GEN && state_q != twst_pkg::ST_START_HOLD
				&& state_q != twst_pkg::ST_STOP_GEN)
			begin
				// Another master took the bus while our start was pending: arbitration is lost.
				if (ctrl_q.startRequest)
					arbLost_q <= 1'b1;
				state_q    <= twst_pkg::ST_ADDR;
				bitCnt_q   <= 4'h0;
				sdaDrive_q <= 1'b0;
			end
			else
			begin
				case (state_q)
					twst_pkg::ST_IDLE:
					begin
						if (ctrl_q.startRequest && !busBusy_q)
						begin
							state_q    <= twst_pkg::ST_START_GEN;
							holdCnt_q  <= 12'h000;
							sdaDrive_q <= 1'b1;
						end
					end
					twst_pkg::ST_ADDR:
					begin
						if (line.sclRise)
						begin
							shift_q  <= {shift_q[6:0], line.sda};
							bitCnt_q <= bitCnt_q + 4'h1;
						end
						else if (line.sclFall && bitCnt_q == 4'h8)
						begin
							if (addressable_q && shift_q[7:1] == own_q[7:1] && shift_q[0])
							begin
								state_q    <= twst_pkg::ST_ADDR_ACK;
								sdaDrive_q <= 1'b1;
							end
							else
							begin
								// General call is a write; flag it for software but do not answer it.
								evGcall_q <= addressable_q && own_q[twst_pkg::OWN_GCE_BIT]
									&& shift_q == 8'h00;
								state_q   <= twst_pkg::ST_IDLE;
							end
						end
					end
					twst_pkg::ST_ADDR_ACK:
					begin
						if (line.sclFall)
						begin
							sdaDrive_q <= 1'b0;
							state_q    <= twst_pkg::ST_TX_HOLD;
							setFlag_q  <= 1'b1;
							setCode_q  <= arbLost_q ? twst_pkg::ST_ARB_LOST_READ : twst_pkg::ST_OWN_READ;
							arbLost_q  <= 1'b0;
						end
					end
					twst_pkg::ST_TX_HOLD:
					begin
						// The first bit goes out on the same edge that releases the held clock, so it has no low phase of its own.
						if (flagClr)
						begin
							shift_q    <= data_q;
							lastByte_q <= ~hwdata[twst_pkg::CTRL_ACK_BIT];
							sdaDrive_q <= ~data_q[7];
							bitCnt_q   <= 4'h1;
							state_q    <= twst_pkg::ST_TX_BITS;
						end
					end
					twst_pkg::ST_TX_BITS:
					begin
						if (line.sclFall)
						begin
							if (bitCnt_q == 4'h8)
							begin
								sdaDrive_q <= 1'b0;
								state_q    <= twst_pkg::ST_TX_ACK;
							end
							else
							begin
								shift_q    <= {shift_q[6:0], 1'b0};
								sdaDrive_q <= ~shift_q[6];
								bitCnt_q   <= bitCnt_q + 4'h1;
							end
						end
					end
					twst_pkg::ST_TX_ACK:
					begin
						if (line.sclRise)
							ackSeen_q <= ~line.sda;
						else if (line.sclFall)
						begin
							setFlag_q <= 1'b1;
							if (!ackSeen_q)
							begin
								setCode_q <= twst_pkg::ST_DATA_NACK;
								state_q   <= twst_pkg::ST_END_HOLD;
							end
							else if (lastByte_q)
							begin
								setCode_q <= twst_pkg::ST_LAST_ACK;
								state_q   <= twst_pkg::ST_END_HOLD;
							end
							else
							begin
								setCode_q <= twst_pkg::ST_DATA_ACK;
								state_q   <= twst_pkg::ST_TX_HOLD;
							end
						end
					end
					twst_pkg::ST_END_HOLD:
					begin
						// A pending start request is kept in the control register and acted on from idle.
						if (flagClr)
						begin
							addressable_q <= hwdata[twst_pkg::CTRL_ACK_BIT];
							state_q       <= twst_pkg::ST_IDLE;
						end
					end
					twst_pkg::ST_START_GEN:
					begin
						holdCnt_q <= holdCnt_q + 12'h001;
						if (holdCnt_q == HOLD_LAST)
						begin
							state_q    <= twst_pkg::ST_START_HOLD;
							setFlag_q  <= 1'b1;
							setCode_q  <= twst_pkg::ST_START_SENT;
							clrStart_q <= 1'b1;
						end
					end
					twst_pkg::ST_START_HOLD:
					begin
						// Master transfers are not built here; clearing the flag ends the attempt with a stop.
						if (flagClr)
						begin
							state_q   <= twst_pkg::ST_STOP_GEN;
							holdCnt_q <= 12'h000;
						end
					end
					twst_pkg::ST_STOP_GEN:
					begin
						holdCnt_q <= holdCnt_q + 12'h001;
						if (holdCnt_q == HOLD_LAST)
						begin
							sdaDrive_q <= 1'b0;
							state_q    <= twst_pkg::ST_IDLE;
						end
					end
					default:
					begin
						state_q <= twst_pkg::ST_IDLE;
					end
				endcase
			end
		end
	end

	// Open-drain pins: the output is always low and the enable pulls the line.
	assign sclOut = 1'b0;
	assign sdaOut = 1'b0;
	assign sclOe  = (state_q == twst_pkg::ST_TX_HOLD) || (state_q == twst_pkg::ST_END_HOLD)
		|| (state_q == twst_pkg::ST_START_HOLD);
	assign sdaOe  = sdaDrive_q;

endmodule : twst_slave_transmitter

`default_nettype wire

// ---- twst_slave_transmitter_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none

module twst_slave_transmitter_assertions
(
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	input  wire logic        hreadyout,
	input  wire logic        hresp,
	input  wire logic [31:0] hrdata,
	input  wire logic        sclIn,
	input  wire logic        sclOut,
	input  wire logic        sclOe,
	input  wire logic        sdaIn,
	input  wire logic        sdaOut,
	input  wire logic        sdaOe,
	input  wire logic        irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	logic       take;
	logic       ctrlTake;
	logic [8:0] hiCnt_q;

	// Accepted transfers; only control writes may let the held bus clock go.
	assign take     = hsel && hready && htrans[1];
	assign ctrlTake = take && hwrite && (haddr[7:0] == twst_pkg::ADDR_CTRL);

	// Counts how long SDA has been pulled while SCL stays high; saturates so it never wraps.
	always_ff @(posedge clock)
	begin
		if (reset || !(sdaOe && sclIn))
			hiCnt_q <= 9'h000;
		else if (hiCnt_q != 9'h1FF)
			hiCnt_q <= hiCnt_q + 9'h001;
	end

	// A read answers after exactly one wait cycle.
	sequence oneWait;
		!hreadyout ##1 hreadyout;
	endsequence

	a_resp_okay: assert property (hresp == 1'b0) else $error("response not OKAY");
	a_read_wait: assert property (take && !hwrite |=> oneWait) else $error("read wait not one cycle");
	a_write_nowait: assert property (take && hwrite |=> hreadyout) else $error("write data phase stalled");
	a_rdata_hold: assert property ($changed(hrdata) |-> $past(take && !hwrite, 2))
		else $error("read data moved without a read");
	a_flag_release: assert property ($past(ctrlTake) && hwdata[7] && sclOe |=> !sclOe)
		else $error("clock held after flag clear");
	a_clock_release: assert property ($fell(sclOe) |-> $past(ctrlTake, 2) && $past(hwdata[7]))
		else $error("clock released without flag clear");
	a_start_hold: assert property ($rose(sclOe) && $past(sclIn) |-> hiCnt_q >= 9'(twst_pkg::START_HOLD_CYCLES - 2))
		else $error("start condition too short");
	a_bit_stands: assert property ($rose(sdaOe) && !sclIn |-> sdaOe[*6])
		else $error("driven low bit too short");
	a_pins_open: assert property (!sclOut && !sdaOut)
		else $error("open drain output driven high");
endmodule : twst_slave_transmitter_assertions

bind twst_slave_transmitter twst_slave_transmitter_assertions twst_slave_transmitter_assertions_inst
(
	.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaIn),
	.sdaOut(sdaOut), .sdaOe(sdaOe), .irq(irq)
);

`default_nettype wire

// ---- twst_slave_transmitter_test.sv ----
`timescale 1ns/10ps
`default_nettype none

module twst_slave_transmitter_test;
	logic        clock, reset, hsel, hwrite, hreadyout, hresp, irq, sclOe, sdaOe, sclLow, sdaLow, ack;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata;
	logic [7:0]  b;
	int          errors, n_checks;
	wire         sclLine = !(sclOe || sclLow);
	wire         sdaLine = !(sdaOe || sdaLow);

	twst_slave_transmitter twst_slave_transmitter_inst
	(
		.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .sclIn(sclLine), .sclOut(), .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(),
		.sdaOe(sdaOe), .irq(irq)
	);

	twst_bus_master twst_bus_master_inst
	(
		.sclLine(sclLine), .sdaLine(sdaLine), .sclLow(sclLow), .sdaLow(sdaLow)
	);

	// Free-running 40 MHz system clock.
	always #12.5 clock = ~clock;

	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One single AHB-Lite transfer; ready and read data are taken at the rising edge, before it updates them.
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clock);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h000000, a};
		hwrite <= wr;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clock); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb

	task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] unused;
		ahb(1'b1, a, d, unused);
	endtask : wrReg

	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
		logic [31:0] d;
		ahb(1'b0, a, 32'h00000000, d);
		chk(what, d, exp);
	endtask : rdChk

	// Waits for the flag interrupt, then checks masking, the status code and the clear.
	task automatic awaitFlag(input logic [7:0] code);
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 4000)
		begin
			@(negedge clock);
			n++;
		end
		wrReg(twst_pkg::ADDR_IRQ_MASK, 32'h00000000);
		@(negedge clock);
		chk("irq masked", {31'h0, irq}, 32'h00000000);
		wrReg(twst_pkg::ADDR_IRQ_MASK, 32'h00000001);
		@(negedge clock);
		chk("irq raised", {31'h0, irq}, 32'h00000001);
		rdChk(twst_pkg::ADDR_STATUS, {24'h0, code}, "status");
		wrReg(twst_pkg::ADDR_IRQ_STAT, 32'h00000001);
		@(negedge clock);
		chk("irq cleared", {31'h0, irq}, 32'h00000000);
	endtask : awaitFlag

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish

	// Cuts a hang short well past the expected few thousand cycles.
	initial
	begin
		repeat (40000) @(posedge clock);
		errors++;
		tally_and_finish();
	end

	// Main sequence: registers, a full transmit, then lost arbitration and a start request.
	initial
	begin
		clock = 1'b0;
		reset = 1'b1;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		rdChk(twst_pkg::ADDR_STATUS, 32'h000000F8, "status idle");
		rdChk(twst_pkg::ADDR_CTRL, 32'h00000000, "ctrl reset");
		wrReg(8'h20, 32'hFFFFFFFF);
		rdChk(8'h20, 32'h00000000, "unmapped");
		wrReg(twst_pkg::ADDR_OWN, 32'h000000A3);
		rdChk(twst_pkg::ADDR_OWN, 32'h000000A3, "own address");
		wrReg(twst_pkg::ADDR_IRQ_MASK, 32'h00000001);
		wrReg(twst_pkg::ADDR_CTRL, 32'h00000044);
		$display("test registers done");
		twst_bus_master_inst.startCond();
		twst_bus_master_inst.sendByte(8'hA3, ack);
		chk("own read acked", {31'h0, ack}, 32'h00000001);
		awaitFlag(twst_pkg::ST_OWN_READ);
		chk("clock held", {31'h0, sclOe}, 32'h00000001);
		rdChk(twst_pkg::ADDR_CTRL, 32'h000000C4, "flag reads set");
		wrReg(twst_pkg::ADDR_DATA, 32'h000000A5);
		wrReg(twst_pkg::ADDR_CTRL, 32'h000000C4);
		twst_bus_master_inst.getByte(1'b1, b);
		chk("byte acked", {24'h0, b}, 32'h000000A5);
		awaitFlag(twst_pkg::ST_DATA_ACK);
		wrReg(twst_pkg::ADDR_DATA, 32'h0000003C);
		wrReg(twst_pkg::ADDR_CTRL, 32'h00000084);
		twst_bus_master_inst.getByte(1'b0, b);
		chk("last byte", {24'h0, b}, 32'h0000003C);
		awaitFlag(twst_pkg::ST_DATA_NACK);
		chk("data released", {31'h0, sdaLine}, 32'h00000001);
		wrReg(twst_pkg::ADDR_CTRL, 32'h00000084);
		twst_bus_master_inst.stopCond();
		twst_bus_master_inst.startCond();
		twst_bus_master_inst.sendByte(8'hA3, ack);
		chk("deaf to own", {31'h0, ack}, 32'h00000000);
		twst_bus_master_inst.startCond();
		twst_bus_master_inst.sendByte(8'h00, ack);
		rdChk(twst_pkg::ADDR_IRQ_STAT, 32'h00000000, "deaf to general call");
		twst_bus_master_inst.stopCond();
		rdChk(twst_pkg::ADDR_STATUS, 32'h000000F8, "not addressed");
		$display("test transmit done");
		wrReg(twst_pkg::ADDR_CTRL, 32'h00000044);
		twst_bus_master_inst.startCond();
		twst_bus_master_inst.sendByte(8'h22, ack);
		wrReg(twst_pkg::ADDR_CTRL, 32'h00000064);
		twst_bus_master_inst.startCond();
		twst_bus_master_inst.sendByte(8'hA3, ack);
		chk("lost then acked", {31'h0, ack}, 32'h00000001);
		awaitFlag(twst_pkg::ST_ARB_LOST_READ);
		wrReg(twst_pkg::ADDR_DATA, 32'h00000081);
		wrReg(twst_pkg::ADDR_CTRL, 32'h00000084);
		twst_bus_master_inst.getByte(1'b1, b);
		chk("byte after loss", {24'h0, b}, 32'h00000081);
		awaitFlag(twst_pkg::ST_LAST_ACK);
		wrReg(twst_pkg::ADDR_CTRL, 32'h000000C4);
		twst_bus_master_inst.stopCond();
		twst_bus_master_inst.startCond();
		twst_bus_master_inst.sendByte(8'h00, ack);
		chk("general call not acked", {31'h0, ack}, 32'h00000000);
		rdChk(twst_pkg::ADDR_IRQ_STAT, 32'h00000004, "general call seen");
		wrReg(twst_pkg::ADDR_IRQ_STAT, 32'h00000004);
		twst_bus_master_inst.startCond();
		twst_bus_master_inst.sendByte(8'hA3, ack);
		chk("own still live", {31'h0, ack}, 32'h00000001);
		awaitFlag(twst_pkg::ST_OWN_READ);
		wrReg(twst_pkg::ADDR_DATA, 32'h0000005A);
		wrReg(twst_pkg::ADDR_CTRL, 32'h00000084);
		twst_bus_master_inst.getByte(1'b0, b);
		awaitFlag(twst_pkg::ST_DATA_NACK);
		wrReg(twst_pkg::ADDR_CTRL, 32'h000000E4);
		twst_bus_master_inst.stopCond();
		awaitFlag(twst_pkg::ST_START_SENT);
		chk("start driven", {31'h0, sdaOe}, 32'h00000001);
		wrReg(twst_pkg::ADDR_CTRL, 32'h00000084);
		repeat (400) @(posedge clock);
		chk("stop released", {31'h0, sdaLine}, 32'h00000001);
		$display("test arbitration done");
		tally_and_finish();
	end
endmodule : twst_slave_transmitter_test

`default_nettype wire
